// ---- irq_status_block.sv ----
// secondary interrupt status, queue pointer and message block status.
// assumes event pulses come from engines on aclk; axi4-lite master on aclk.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - status flags latch on their event regardless of enable bits
// - bit 15 reads one while any lower event bit is pending
// - bit 14 sets on sequencer instruction parity error
// - bit 13: illegal command in terminal, stored message in monitor
// - bit 12: general queue rollover in controller, status queue otherwise
// - bit 11 sets on call stack overflow or underflow in controller mode
// - bit 10 sets on illegal opcode fetch
// - bits 9..6 set at half occupancy of four stacks and buffers
// - irq instruction in controller mode copies parameter low four bits into bits 5..2
// - bit 1 sets when a self-test run finishes
// - bit 0 reads one while first status register has any bit set
// - interrupt request only for enabled events; flags still latch
// - queue pointer serves general queue or status queue by mode
// - pointer holds writable base 15..6 and next offset 5..0
// - block status word written to ram at message end; host may rewrite
// - finished bit set at message completion, errors or not
// - active bit set at message start, cleared at its end
// - bit 13 records bus b as one, bus a as zero
// - error flag with bits 10..8, or alone for handshake failure
// - bit 8 flags loopback validity failure or last word mismatch
// - bit 11 flags unexpected status bits 10..0, mask bits ignored
module irq_status_block #(
   parameter int addr_width = 10
) (
   input wire logic aclk,
   input wire logic aresetn,

   // axi4-lite slave
   input wire logic [addr_width-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [addr_width-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,

   // event pulses from the engines
   input wire logic instruction_parity_fault,
   input wire logic illegal_command_or_msg_stored,
   input wire logic queue_write,
   input wire logic call_stack_fault,
   input wire logic bad_opcode_fetch,
   input wire logic term_cmd_stack_half,
   input wire logic term_circ_buffer_half,
   input wire logic mon_cmd_stack_half,
   input wire logic mon_data_stack_half,
   input wire logic irq_instruction,
   input wire logic [3:0] irq_param_low_bits,
   input wire logic self_test_done,
   input wire logic first_status_any_set,

   // controller message events
   input wire logic message_start,
   input wire logic message_end,
   input wire logic message_on_bus_b,
   input wire logic format_error,
   input wire logic timeout_error,
   input wire logic loopback_invalid,
   input wire logic loopback_mismatch,
   input wire logic handshake_failure,
   input wire logic [10:0] status_word_low,
   input wire logic [10:0] status_expected,

   // outputs
   output logic irq_request,
   output logic [15:0] queue_pointer,
   output logic [15:0] block_status_word,
   output logic block_status_write
);
   // decode needs the ten low bits
   generate
      if (addr_width < 10 || addr_width > 32) begin : bad_width
         $error("addr_width must lie between 10 and 32");
      end
   endgenerate

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // host words and mode
   logic [15:0] status_q, status_d;
   logic [15:0] enable_q;
   logic [15:0] queue_q, queue_d;
   logic [15:0] block_q, block_d;
   logic [1:0] mode_q;

   // ram write strobe
   logic bsw_write_q;

   // bus response state
   logic bvalid_q, rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] bresp_q, rresp_q;

   // early write halves
   logic aw_held_q, w_held_q;
   logic [addr_width-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // ----------------------------------------------------------------
   // write channel capture, either order
   // ----------------------------------------------------------------
   // valid meets ready
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;

   // both halves in hand
   wire aw_have = aw_held_q || aw_take;
   wire w_have = w_held_q || w_take;
   wire wr_fire = aw_have && w_have && !bvalid_q;

   // held half or live channel
   wire [addr_width-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
   wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
   wire [9:0] wr_low = wr_addr[9:0];
   wire wr_upper_zero = (addr_width == 10) ? 1'b1 : (wr_addr >> 10) == '0;

   // one select per register
   wire wr_enable = wr_fire && wr_upper_zero && wr_low == irq_status_pkg::addr_enable;
   wire wr_queue = wr_fire && wr_upper_zero && wr_low == irq_status_pkg::addr_queue;
   wire wr_block = wr_fire && wr_upper_zero && wr_low == irq_status_pkg::addr_block;
   wire wr_control = wr_fire && wr_upper_zero && wr_low == irq_status_pkg::addr_control;
   wire wr_status = wr_fire && wr_upper_zero && wr_low == irq_status_pkg::addr_status;
   wire wr_mapped = wr_enable || wr_queue || wr_block || wr_control || wr_status;

   // lanes 0 and 1 only
   wire [15:0] wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

   // stall while bvalid waits
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   // take a read when idle
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire [9:0] rd_low = s_axi_araddr[9:0];
   wire rd_upper_zero = (addr_width == 10) ? 1'b1 : (s_axi_araddr >> 10) == '0;
   logic [31:0] rd_value;
   logic rd_ok;
   assign s_axi_arready = !rvalid_q;

   // read mux, zero if unmapped
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_ok = 1'b1;
      if (rd_upper_zero && rd_low == irq_status_pkg::addr_status) begin
         rd_value = {16'h0000, status_q};
      end else if (rd_upper_zero && rd_low == irq_status_pkg::addr_enable) begin
         rd_value = {16'h0000, enable_q};
      end else if (rd_upper_zero && rd_low == irq_status_pkg::addr_queue) begin
         rd_value = {16'h0000, queue_q};
      end else if (rd_upper_zero && rd_low == irq_status_pkg::addr_block) begin
         rd_value = {16'h0000, block_q};
      end else if (rd_upper_zero && rd_low == irq_status_pkg::addr_control) begin
         rd_value = {30'h0000_0000, mode_q};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   // mode and queue wrap
   wire is_ctrl = mode_q == irq_status_pkg::mode_controller;
   wire offset_wraps = queue_write && (&queue_q[irq_status_pkg::queue_offset_width-1:0]);
   // half events, bits 9..6
   wire [3:0] half_events = {term_cmd_stack_half, term_circ_buffer_half,
                             mon_cmd_stack_half, mon_data_stack_half};

   // host clear mask
   wire status_clear = wr_status;  // write-one-to-clear of sticky flags
   wire [15:0] clear_mask = status_clear ? (wr_data[15:0] & wr_mask) : 16'h0000;

   // set line per sticky bit
   logic [14:1] event_set;

   // gather one-cycle event pulses by bit
   always_comb begin
      event_set = '0;
      event_set[irq_status_pkg::bit_parity] = instruction_parity_fault;
      event_set[irq_status_pkg::bit_illegal] = illegal_command_or_msg_stored && !is_ctrl;
      event_set[irq_status_pkg::bit_rollover] = offset_wraps;
      event_set[irq_status_pkg::bit_stack] = call_stack_fault && is_ctrl;
      event_set[irq_status_pkg::bit_opcode] = bad_opcode_fetch;
      event_set[9:6] = half_events;
      event_set[irq_status_pkg::bit_selftest] = self_test_done;
   end

   // sticky flags: set wins over clear, enable not consulted
   always_comb begin
      status_d = status_q;
      // sticky bits outside 5..2
      for (int i = 1; i <= 14; i++) begin
         if (i < irq_status_pkg::bit_irq_lo || i > 5) begin
            status_d[i] = event_set[i] | (status_q[i] & ~clear_mask[i]);
         end
      end

      // irq load beats a clear
      if (irq_instruction && is_ctrl) begin
         status_d[5:2] = irq_param_low_bits;
      end else begin
         status_d[5:2] = status_q[5:2] & ~clear_mask[5:2];
      end

      // derived bits
      status_d[irq_status_pkg::bit_chain] = first_status_any_set;
      status_d[irq_status_pkg::bit_pending] = |status_d[14:0];
   end

   // request only for enabled flags
   assign irq_request = |(status_q[14:0] & enable_q[14:0]);

   // ----------------------------------------------------------------
   // queue pointer
   // ----------------------------------------------------------------
   // host write beats a step
   always_comb begin
      queue_d = queue_q;
      if (wr_queue) begin
         queue_d = (queue_q & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end else if (queue_write) begin
         // one pointer, meaning chosen by mode
         queue_d[5:0] = queue_q[5:0] + 6'h01;
      end
   end
   // pointer seen by engines
   assign queue_pointer = queue_q;

   // ----------------------------------------------------------------
   // block status word
   // ----------------------------------------------------------------
   // errors seen at message end
   wire any_err = format_error || timeout_error || loopback_invalid || loopback_mismatch;
   wire lb_fault = loopback_invalid || loopback_mismatch;
   wire unexpected = status_word_low != status_expected;

   // host edits, then engine
   always_comb begin
      block_d = block_q;
      if (wr_block) begin
         block_d = (block_q & ~wr_mask) | (wr_data[15:0] & wr_mask);
      end
      // fresh word per message
      if (message_start && is_ctrl) begin
         block_d = 16'h0000;
         block_d[irq_status_pkg::bsw_active] = 1'b1;
         block_d[irq_status_pkg::bsw_bus] = message_on_bus_b;
      end else if (message_end && is_ctrl) begin
         // completion fields
         block_d[irq_status_pkg::bsw_finished] = 1'b1;
         block_d[irq_status_pkg::bsw_active] = 1'b0;
         block_d[irq_status_pkg::bsw_bus] = message_on_bus_b;
         block_d[irq_status_pkg::bsw_error] = any_err || handshake_failure;
         block_d[irq_status_pkg::bsw_unexpected] = unexpected;
         block_d[irq_status_pkg::bsw_format] = format_error;
         block_d[irq_status_pkg::bsw_timeout] = timeout_error;
         block_d[irq_status_pkg::bsw_loopback] = lb_fault;
      end
   end

   // word and strobe together
   assign block_status_word = block_q;
   assign block_status_write = bsw_write_q;

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   // synchronous reset to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= irq_status_pkg::reset_status;
         enable_q <= irq_status_pkg::reset_enable;
         queue_q <= irq_status_pkg::reset_queue;
         block_q <= irq_status_pkg::reset_block;
         mode_q <= irq_status_pkg::reset_mode;
         bsw_write_q <= 1'b0;
      end else begin
         status_q <= status_d;
         queue_q <= queue_d;
         block_q <= block_d;
         // strobe with the word
         bsw_write_q <= message_end && is_ctrl;

         // host-only registers
         if (wr_enable) begin
            enable_q <= (enable_q & ~wr_mask) | (wr_data[15:0] & wr_mask);
         end
         // mode code 3 ignored
         if (wr_control && wr_strb[0] && wr_data[1:0] != 2'h3) begin
            mode_q <= wr_data[1:0];
         end
      end
   end

   // write channel holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= irq_status_pkg::resp_okay;
      end else begin
         // park first half
         if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         // consume on fire
         aw_held_q <= aw_have && !wr_fire;
         w_held_q <= w_have && !wr_fire;

         // hold until bready
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? irq_status_pkg::resp_okay : irq_status_pkg::resp_slverr;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= irq_status_pkg::resp_okay;
      end else if (ar_take) begin
         // answer next cycle
         rvalid_q <= 1'b1;
         rdata_q <= rd_value;
         rresp_q <= rd_ok ? irq_status_pkg::resp_okay : irq_status_pkg::resp_slverr;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // responses from registers
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// ---- irq_status_pkg.sv ----
// package: register offsets, field positions and reset values of the
// secondary interrupt status block.
// assumes a 32-bit axi4-lite bus with one aligned word per register.
package irq_status_pkg;
   // ----------------------------------------------------------------
   // register indices (printed offsets) and byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] idx_enable = 8'h1d;
   localparam logic [7:0] idx_status = 8'h1e;
   localparam logic [7:0] idx_queue = 8'h1f;
   localparam logic [7:0] idx_block = 8'h20;
   localparam logic [7:0] idx_control = 8'h21;
   localparam logic [9:0] addr_enable = {idx_enable, 2'b00};
   localparam logic [9:0] addr_status = {idx_status, 2'b00};
   localparam logic [9:0] addr_queue = {idx_queue, 2'b00};
   localparam logic [9:0] addr_block = {idx_block, 2'b00};
   localparam logic [9:0] addr_control = {idx_control, 2'b00};
   // ----------------------------------------------------------------
   // status field positions
   // ----------------------------------------------------------------
   localparam int bit_pending = 15;
   localparam int bit_parity = 14;
   localparam int bit_illegal = 13;
   localparam int bit_rollover = 12;
   localparam int bit_stack = 11;
   localparam int bit_opcode = 10;
   localparam int bit_half_lo = 6;
   localparam int bit_irq_lo = 2;
   localparam int bit_selftest = 1;
   localparam int bit_chain = 0;
   // ----------------------------------------------------------------
   // queue pointer and block status fields
   // ----------------------------------------------------------------
   localparam int queue_offset_width = 6;
   localparam int bsw_finished = 15;
   localparam int bsw_active = 14;
   localparam int bsw_bus = 13;
   localparam int bsw_error = 12;
   localparam int bsw_unexpected = 11;
   localparam int bsw_format = 10;
   localparam int bsw_timeout = 9;
   localparam int bsw_loopback = 8;
   // ----------------------------------------------------------------
   // reset values and modes
   // ----------------------------------------------------------------
   localparam logic [15:0] reset_status = 16'h0000;
   localparam logic [15:0] reset_enable = 16'h0000;
   localparam logic [15:0] reset_queue = 16'h0000;
   localparam logic [15:0] reset_block = 16'h0000;
   localparam logic [1:0] reset_mode = 2'h0;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   typedef enum logic [1:0] {mode_controller, mode_terminal, mode_monitor} mode_t;
endpackage

// ---- irq_status_props.sv ----
// checker: timing relations on the ports of the status block.
// assumes a bind into irq_status_block, one aclk domain.
`timescale 1ns/100ps
`default_nettype none
module irq_status_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic queue_write,
   input wire logic message_start,
   input wire logic message_end,
   input wire logic message_on_bus_b,
   input wire logic format_error,
   input wire logic timeout_error,
   input wire logic loopback_invalid,
   input wire logic loopback_mismatch,
   input wire logic handshake_failure,
   input wire logic [10:0] status_word_low,
   input wire logic [10:0] status_expected,
   input wire logic [15:0] queue_pointer,
   input wire logic [15:0] block_status_word,
   input wire logic block_status_write
);
   // ------------------------------------------------------------
   // message steps
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_started;
      block_status_word[14] && !block_status_word[15];
   endsequence
   sequence s_finished;
      block_status_write && block_status_word[15] && !block_status_word[14];
   endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_start_active: assert property (message_start |=> s_started)
      else $error("active bit missing after start");
   a_end_write: assert property (message_end |=> s_finished)
      else $error("finished word not written after end");
   a_write_pulse: assert property (block_status_write |=> !block_status_write)
      else $error("word write pulse too long");
   a_bus_bit: assert property (block_status_write |->
      block_status_word[13] == $past(message_on_bus_b))
      else $error("bus bit wrong");
   a_error_flag: assert property (block_status_write |-> block_status_word[12] ==
      $past(format_error | timeout_error | loopback_invalid | loopback_mismatch |
      handshake_failure))
      else $error("error flag wrong");
   a_error_fields: assert property (block_status_write |-> block_status_word[10:8] ==
      $past({format_error, timeout_error, loopback_invalid | loopback_mismatch}))
      else $error("error fields wrong");
   a_status_set: assert property (block_status_write |->
      block_status_word[11] == $past(status_word_low != status_expected))
      else $error("status set bit wrong");
   a_queue_step: assert property (queue_write && !s_axi_awvalid && !s_axi_wvalid |=>
      queue_pointer == {$past(queue_pointer[15:6]), $past(queue_pointer[5:0]) + 6'h01})
      else $error("queue offset did not advance");
endmodule
bind irq_status_block irq_status_props u_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_wvalid(s_axi_wvalid), .queue_write(queue_write), .message_start(message_start),
   .message_end(message_end), .message_on_bus_b(message_on_bus_b),
   .format_error(format_error), .timeout_error(timeout_error),
   .loopback_invalid(loopback_invalid), .loopback_mismatch(loopback_mismatch),
   .handshake_failure(handshake_failure), .status_word_low(status_word_low),
   .status_expected(status_expected), .queue_pointer(queue_pointer),
   .block_status_word(block_status_word), .block_status_write(block_status_write)
);
`default_nettype wire

// ---- host_ram_model.sv ----
// partner: the shared ram word the host reads after each message.
// assumes the block's write pulse and word on aclk.
`timescale 1ns/100ps
`default_nettype none
module host_ram_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic block_status_write,
   input wire logic [15:0] block_status_word,
   output logic [15:0] ram_word_q,
   output logic ram_written_q
);
   // store the finished word where the host finds it
   always_ff @(posedge aclk) begin
      ram_written_q <= aresetn && block_status_write;
      if (block_status_write) begin
         ram_word_q <= block_status_word;
      end
   end
endmodule
`default_nettype wire

// ---- secondary_irq_status_and_block_status_tb.sv ----
// testbench: status flags, queue pointer and block word of the status block.
// assumes the host ram model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module secondary_irq_status_and_block_status_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fsa, bus, irq, bsw_wr, ram_wr;
   logic awready, wready, bvalid, arready, rvalid;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata, r;
   logic [1:0] bresp, rresp;
   logic [15:0] ev, qp, bsw, ram_word;
   logic [3:0] prm, p;
   logic [4:0] er;
   logic [10:0] swl, swe;
   logic [65:0] rq[$];
   logic [15:0] mq[$];
   int miscompares, n_tests, seed, m;
   int bits[8] = '{14, 11, 10, 9, 8, 7, 6, 1};
   irq_status_block DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .instruction_parity_fault(ev[14]), .illegal_command_or_msg_stored(ev[13]),
      .queue_write(ev[12]), .call_stack_fault(ev[11]), .bad_opcode_fetch(ev[10]),
      .term_cmd_stack_half(ev[9]), .term_circ_buffer_half(ev[8]), .mon_cmd_stack_half(ev[7]),
      .mon_data_stack_half(ev[6]), .irq_instruction(ev[2]), .irq_param_low_bits(prm),
      .self_test_done(ev[1]), .first_status_any_set(fsa), .message_start(ev[15]),
      .message_end(ev[0]), .message_on_bus_b(bus), .format_error(er[4]),
      .timeout_error(er[3]), .loopback_invalid(er[2]), .loopback_mismatch(er[1]),
      .handshake_failure(er[0]), .status_word_low(swl), .status_expected(swe),
      .irq_request(irq), .queue_pointer(qp), .block_status_word(bsw),
      .block_status_write(bsw_wr));
   host_ram_model u_host (.aclk(aclk), .aresetn(aresetn), .block_status_write(bsw_wr),
      .block_status_word(bsw), .ram_word_q(ram_word), .ram_written_q(ram_wr));
   // ------------------------------------------------------------
   // clock, compare and bus tasks
   // ------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one axi4-lite transfer; expected read result goes to the queue
   task xfer(input logic is_rd, input logic [9:0] a, input logic [15:0] d,
      input logic [15:0] k, input logic [1:0] rs);
      logic pa, pw, pr, ta, tw, tr;
      int n;
      pr = is_rd;
      pa = !is_rd;
      pw = !is_rd;
      if (is_rd) rq.push_back({rs, 16'hffff, k, 16'h0000, d});
      araddr <= a;
      awaddr <= a;
      wdata <= {16'h0000, d};
      arvalid <= pr;
      awvalid <= pa;
      wvalid <= pw;
      for (n = 0; n < 64 && (pa || pw || pr); n++) begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         tr = arready;
         @(posedge aclk);
         pa = pa && !ta;
         pw = pw && !tw;
         pr = pr && !tr;
         awvalid <= pa;
         wvalid <= pw;
         arvalid <= pr;
      end
      while (n < 128 && (is_rd ? rvalid : bvalid) !== 1'b1) begin
         @(negedge aclk);
         n++;
      end
      if (n >= 128) begin
         miscompares++;
         print_verdict;
      end
      @(posedge aclk);
   endtask
   task rd(input logic [9:0] a, input logic [15:0] d, input logic [15:0] k = 16'hffff);
      xfer(1'b1, a, d, k, irq_status_pkg::resp_okay);
   endtask
   task wr(input logic [9:0] a, input logic [15:0] d);
      xfer(1'b0, a, d, 16'h0000, irq_status_pkg::resp_okay);
   endtask
   task pulse(input logic [15:0] v);
      ev <= v;
      @(posedge aclk);
      ev <= 16'h0000;
      @(posedge aclk);
   endtask
   // watch read answers and ram words, oldest note first
   always @(posedge aclk) begin
      logic [65:0] e;
      if (rvalid && rready) begin
         e = rq.pop_front();
         chk("rdata", e[31:0] & e[63:32], rdata & e[63:32]);
         chk("rresp", e[65:64], rresp);
      end
      if (ram_wr) chk("ram word", mq.pop_front(), ram_word);
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      seed = 95981;
      {aresetn, awvalid, wvalid, arvalid, fsa, bus, ev, prm, er, swl, swe} = '0;
      {awaddr, araddr, wdata} = '0;
      {bready, rready} = 2'b11;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(irq_status_pkg::addr_status, irq_status_pkg::reset_status);
      rd(irq_status_pkg::addr_queue, irq_status_pkg::reset_queue);
      xfer(1'b1, 10'h3fc, 16'h0000, 16'hffff, irq_status_pkg::resp_slverr);
      $display("test reset done");
      foreach (bits[i]) begin
         pulse(16'h0001 << bits[i]);
         rd(irq_status_pkg::addr_status, 16'h8000 | (16'h0001 << bits[i]));
         chk("irq masked", 1'b0, irq);
         wr(irq_status_pkg::addr_status, 16'hffff);
      end
      for (m = 0; m < 3; m++) begin
         wr(irq_status_pkg::addr_control, 16'(m));
         wr(irq_status_pkg::addr_queue, 16'h5a7f);
         pulse(16'h3800);
         rd(irq_status_pkg::addr_status, {2'b10, m != 0, 1'b1, m == 0, 11'h0});
         chk("queue pointer", 16'h5a40, qp);
         wr(irq_status_pkg::addr_status, 16'hffff);
      end
      wr(irq_status_pkg::addr_control, 16'h0000);
      repeat (4) begin
         p = 4'($random(seed));
         prm <= p;
         pulse(16'h0004);
         rd(irq_status_pkg::addr_status, {p != 4'h0, 9'h0, p, 2'h0});
      end
      wr(irq_status_pkg::addr_enable, 16'h4000);
      pulse(16'h4000);
      chk("irq enabled", 1'b1, irq);
      wr(irq_status_pkg::addr_enable, 16'h0000);
      chk("irq masked", 1'b0, irq);
      rd(irq_status_pkg::addr_status, 16'hc000 | {10'h0, p, 2'h0});
      wr(irq_status_pkg::addr_status, 16'hffff);
      fsa <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(irq_status_pkg::addr_status, 16'h8001);
      fsa <= 1'b0;
      repeat (2) @(posedge aclk);
      rd(irq_status_pkg::addr_status, 16'h0000);
      $display("test status done");
      repeat (8) begin
         r = $random(seed);
         {bus, er, swl} <= r[16:0];
         swe <= r[31] ? r[10:0] : ~r[10:0];
         mq.push_back({2'b10, r[16], |r[15:11], !r[31], r[15], r[14], r[13] | r[12], 8'h00});
         pulse(16'h8000);
         pulse(16'h0001);
         repeat (2) @(posedge aclk);
      end
      wr(irq_status_pkg::addr_block, 16'h1234);
      rd(irq_status_pkg::addr_block, 16'h1234);
      $display("test message done");
      print_verdict;
   end
endmodule
`default_nettype wire
